/* include/mif_pkg.sv */
package mif_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [7:0] IDX_CPU_CTRL    = 8'h35;
    localparam logic [7:0] IDX_TMR_FLAGS   = 8'h38;
    localparam logic [7:0] IDX_TMR_MASK    = 8'h39;
    localparam logic [7:0] IDX_EXT_FLAGS   = 8'h3a;
    localparam logic [7:0] IDX_EXT_MASK    = 8'h3b;
    localparam logic [7:0] IDX_GLOBAL_CTRL = 8'h3f;

    // Field positions
    localparam int EXT_ONE_BIT  = 7;
    localparam int EXT_ZERO_BIT = 6;
    localparam int GIE_BIT      = 7;

    // Timer bit 1 is reserved
    localparam logic [7:0] TMR_VALID = 8'hfd;

    // Reset values
    localparam logic [7:0] RST_REG8  = 8'h00;
    localparam logic [3:0] RST_SENSE = 4'h0;

    // Sense control encodings
    localparam logic [1:0] SENSE_LOW  = 2'h0;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    // Source count; source n vectors to address n+1
    localparam int NUM_SRC = 9;

    // Cycles spent pushing the return address before the vector is issued
    localparam logic [2:0] ENTRY_CYCLES = 3'h4;

    typedef enum logic [0:0] {
        PH_RUN,
        PH_ENTRY
    } mif_phase_t;

    typedef struct packed {
        logic [1:0]  sync1;
        logic [1:0]  sync2;
        logic [1:0]  pin_prev;
        logic [1:0]  ext_irq_mask;
        logic [1:0]  ext_flag;
        logic [3:0]  sense;
        logic [7:0]  timer_irq_mask;
        logic [7:0]  timer_irq_flags;
        logic        gie;
        logic        ret_hold;
        logic        pend;
        mif_phase_t  phase;
        logic [2:0]  cnt;
        logic [3:0]  vec;
        logic        vec_valid;
        logic        ack;
        logic [31:0] dat;
    } mif_state_t;

endpackage

/* logic/mif_unit.sv */
`timescale 1ns/1ps
module mif_unit (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [1:0]  ext_pin_i,
    input  wire logic [7:0]  timer_evt_i,
    input  wire logic        instr_done_i,
    input  wire logic        return_i,
    output logic             irq_pending_o,
    output logic             entry_busy_o,
    output logic             vector_valid_o,
    output logic      [3:0]  vector_addr_o,
    output logic             global_enable_o
);

    // Overview of the unit
    // Two external pins, seven timer events, one global enable
    // Pins are asynchronous: two flops, then a third for edges
    // Timer events arrive on this clock, so no synchroniser
    // Each source has a flag and a local mask bit
    // Level-sensed pins have no flag; the live pin requests
    // Requests are ordered by vector address, lowest first
    // A registered summary of requests feeds the take logic
    // Take happens only at an instruction boundary
    // Take also needs the global enable and no return hold
    // Entry runs four cycles while the core pushes the return address
    // Vector pulse marks the jump; the served flag clears then
    // A new event on the served flag in that cycle survives
    // Status register saving is left to software entirely
    //
    // Bus side
    // Classic single cycle; ack exactly one cycle after the request
    // Ack and read data stand for one cycle only
    // A held strobe is not answered twice back to back
    // Unmapped words answer with zero and ignore writes
    // Only byte lane 0 carries register data
    // Write with lane 0 disabled is answered but has no effect
    //
    // Latency budget
    // Flag set at edge N, pending at N+1, take at N+2 earliest
    // Vector pulse at N+6, which meets the four cycle minimum
    // The stale pending bit costs one cycle, never a lost request
    //
    // Hazards
    // Sense change while a pin is steady makes no false edge
    // Reserved sense code sets no flag; a flag already set is kept and still requests
    // Global enable: entry beats return beats a software write
    // A return and a boundary together keep the return hold
    mif_pkg::mif_state_t st;
    mif_pkg::mif_state_t next_st;

    logic [1:0]                 edge_evt;
    logic [1:0]                 level_mode;
    logic [1:0]                 level_req;
    logic [mif_pkg::NUM_SRC-1:0] src_req;
    logic [mif_pkg::NUM_SRC-1:0] src_clr;
    logic [7:0]                 tmr_req;
    logic [7:0]                 tmr_clr;
    logic [7:0]                 idx;
    logic [7:0]                 wdat;
    logic                       acc;
    logic                       wr;
    logic                       take;
    logic                       finish;
    logic [3:0]                 win_vec;
    logic                       any_req;

    // Per-pin trigger detection on the synchronised level; pin direction plays no part
    for (genvar p = 0; p < 2; p++)
    begin : g_pin
        logic [1:0] sel_sense;
        assign sel_sense     = st.sense[2*p+1 -: 2];
        assign level_mode[p] = (sel_sense == mif_pkg::SENSE_LOW);
        assign edge_evt[p]   = ((sel_sense == mif_pkg::SENSE_RISE) & st.sync2[p] & ~st.pin_prev[p])
                             | ((sel_sense == mif_pkg::SENSE_FALL) & ~st.sync2[p] & st.pin_prev[p]);
        assign level_req[p]  = level_mode[p] & ~st.sync2[p];
    end

    // Request vector ordered by vector address, index n is vector n+1
    // Pin zero sits first, then pin one, then the timer sources
    // Reserved timer bit 1 is masked off before it can request
    always_comb
    begin
        tmr_req = st.timer_irq_flags & st.timer_irq_mask & mif_pkg::TMR_VALID;
        src_req[0] = st.ext_irq_mask[0] & (level_mode[0] ? level_req[0] : st.ext_flag[0]);
        src_req[1] = st.ext_irq_mask[1] & (level_mode[1] ? level_req[1] : st.ext_flag[1]);
        src_req[2] = tmr_req[7];
        src_req[3] = tmr_req[6];
        src_req[4] = tmr_req[5];
        src_req[5] = tmr_req[4];
        src_req[6] = tmr_req[3];
        src_req[7] = tmr_req[2];
        src_req[8] = tmr_req[0];
    end

    // Fixed priority, scanning down so the lowest index is left standing
    always_comb
    begin
        win_vec = 4'h0;
        any_req = |src_req;
        for (int s = mif_pkg::NUM_SRC - 1; s >= 0; s--)
        begin
            if (src_req[s])
            begin
                win_vec = 4'(s + 1);
            end
        end
    end

    // Hardware clear of the served source at the moment the vector is issued
    // Clearing at the jump, not at take, keeps the flag visible while busy
    // Level sources have no flag, so their clear is simply unused
    always_comb
    begin
        src_clr = '0;
        for (int s = 0; s < mif_pkg::NUM_SRC; s++)
        begin
            if (finish && st.vec == 4'(s + 1))
            begin
                src_clr[s] = 1'b1;
            end
        end
        tmr_clr = {src_clr[2], src_clr[3], src_clr[4], src_clr[5],
                   src_clr[6], src_clr[7], 1'b0, src_clr[8]};
    end

    // Bus decode and sequencing terms
    always_comb
    begin
        idx    = wb_adr_i[9:2];
        wdat   = wb_dat_i[7:0];
        acc    = wb_cyc_i & wb_stb_i & ~st.ack;
        wr     = acc & wb_we_i & wb_sel_i[0];
        // Only at an instruction boundary, and never the one right after a return
        take   = (st.phase == mif_pkg::PH_RUN) & st.pend & st.gie & ~st.ret_hold
               & instr_done_i;
        finish = (st.phase == mif_pkg::PH_ENTRY) & (st.cnt == mif_pkg::ENTRY_CYCLES - 3'h1);
    end

    // Next state
    always_comb
    begin
        next_st = st;

        // Two-stage pin synchroniser, then a third stage for edges
        next_st.sync1    = ext_pin_i;
        next_st.sync2    = st.sync1;
        next_st.pin_prev = st.sync2;

        // Single-cycle ack, so a held strobe is not answered twice back to back
        next_st.ack       = acc;
        next_st.dat       = 32'h0000_0000;
        next_st.vec_valid = 1'b0;

        if (acc && !wb_we_i)
        begin
            if (idx == mif_pkg::IDX_EXT_MASK)
            begin
                next_st.dat[7:6] = st.ext_irq_mask;
            end
            else if (idx == mif_pkg::IDX_EXT_FLAGS)
            begin
                next_st.dat[7:6] = st.ext_flag;
            end
            else if (idx == mif_pkg::IDX_TMR_MASK)
            begin
                next_st.dat[7:0] = st.timer_irq_mask;
            end
            else if (idx == mif_pkg::IDX_TMR_FLAGS)
            begin
                next_st.dat[7:0] = st.timer_irq_flags;
            end
            else if (idx == mif_pkg::IDX_CPU_CTRL)
            begin
                next_st.dat[3:0] = st.sense;
            end
            else if (idx == mif_pkg::IDX_GLOBAL_CTRL)
            begin
                next_st.dat[mif_pkg::GIE_BIT] = st.gie;
            end
        end

        // Plain control writes; reserved bits are never stored
        if (wr && idx == mif_pkg::IDX_EXT_MASK)
        begin
            next_st.ext_irq_mask = wdat[mif_pkg::EXT_ONE_BIT:mif_pkg::EXT_ZERO_BIT];
        end
        if (wr && idx == mif_pkg::IDX_TMR_MASK)
        begin
            next_st.timer_irq_mask = wdat & mif_pkg::TMR_VALID;
        end
        if (wr && idx == mif_pkg::IDX_CPU_CTRL)
        begin
            next_st.sense = wdat[3:0];
        end

        // Edge flags: set wins over a write-one or vector clear; level mode holds zero
        for (int p = 0; p < 2; p++)
        begin
            if (level_mode[p])
            begin
                next_st.ext_flag[p] = 1'b0;
            end
            else
            begin
                next_st.ext_flag[p] = (st.ext_flag[p]
                    & ~(wr && idx == mif_pkg::IDX_EXT_FLAGS && wdat[mif_pkg::EXT_ZERO_BIT + p])
                    & ~src_clr[p]) | edge_evt[p];
            end
        end

        // Timer flags latch regardless of mask; same set-wins policy
        next_st.timer_irq_flags = ((st.timer_irq_flags
            & ~((wr && idx == mif_pkg::IDX_TMR_FLAGS) ? wdat : 8'h00)
            & ~tmr_clr) | timer_evt_i) & mif_pkg::TMR_VALID;

        // Global enable: software write, then return, then entry take precedence
        if (wr && idx == mif_pkg::IDX_GLOBAL_CTRL)
        begin
            next_st.gie = wdat[mif_pkg::GIE_BIT];
        end
        if (return_i)
        begin
            next_st.gie = 1'b1;
        end
        if (take)
        begin
            next_st.gie = 1'b0;
        end

        // One instruction after a return must complete before the next take
        if (return_i)
        begin
            next_st.ret_hold = 1'b1;
        end
        else if (instr_done_i)
        begin
            next_st.ret_hold = 1'b0;
        end

        // Registered request summary; one cycle stale, which only adds latency
        next_st.pend = any_req;

        // Entry sequence; the core pushes the return address only, never status
        case (st.phase)
            mif_pkg::PH_RUN:
            begin
                next_st.cnt = 3'h0;
                if (take)
                begin
                    next_st.phase = mif_pkg::PH_ENTRY;
                    next_st.vec   = win_vec;
                end
            end
            mif_pkg::PH_ENTRY:
            begin
                next_st.cnt = st.cnt + 3'h1;
                if (finish)
                begin
                    next_st.phase     = mif_pkg::PH_RUN;
                    next_st.vec_valid = 1'b1;
                    next_st.cnt       = 3'h0;
                end
            end
            default:
            begin
                next_st.phase = mif_pkg::PH_RUN;
            end
        endcase
    end

    // Notes on the state register
    // One packed struct holds every bit of state
    // The combinational block fills a full copy each cycle
    // Reset clears the whole struct, then names key fields again
    // Naming them keeps the reset intent visible to readers
    // Synchroniser stages reset low, matching a low idle pin
    // A pin idling high after reset gives at most a rising edge
    // That edge only matters in rising mode, off after reset
    // Sense resets to level mode, but all masks are off
    // So no request can leave the unit straight after reset
    // The phase resets to run with a cleared entry counter
    // Ack and read data reset low, so no answer is pending
    // The vector address resets to zero, outside the valid range
    // Return hold resets clear, so the first take is not delayed
    // Pending summary resets clear and refills one cycle later
    //
    // Limitations
    // No pin direction input; pins are always sampled
    // Timer event pulses longer than a cycle just set again
    // Vector address holds from entry start to the next entry
    // A request that vanishes mid entry still gets its vector
    // Level requests must stay low until the boundary to count
    //
    // Trade-offs
    // Registered pending adds a cycle but shortens the take path
    // Fixed priority scan is small for nine sources
    // Set-wins flags never lose an event to a racing clear
    // State register; everything resets to zero so nothing is enabled or pending
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st                 <= '0;
            st.ext_irq_mask    <= mif_pkg::RST_REG8[1:0];
            st.ext_flag        <= mif_pkg::RST_REG8[1:0];
            st.timer_irq_mask  <= mif_pkg::RST_REG8;
            st.timer_irq_flags <= mif_pkg::RST_REG8;
            st.sense           <= mif_pkg::RST_SENSE;
            st.phase           <= mif_pkg::PH_RUN;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    // Busy decodes the single phase bit, so it stays glitch free
    // Read data is zero outside an answer to ease bus muxing
    // Pending ignores the global enable; software may poll it
    assign wb_ack_o        = st.ack;
    assign wb_dat_o        = st.dat;
    assign irq_pending_o   = st.pend;
    assign entry_busy_o    = (st.phase == mif_pkg::PH_ENTRY);
    assign vector_valid_o  = st.vec_valid;
    assign vector_addr_o   = st.vec;
    assign global_enable_o = st.gie;

endmodule // mif_unit

/* dv/mif_unit_monitor.sv */
`timescale 1ns/1ps
module mif_unit_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        instr_done_i,
    input wire logic        return_i,
    input wire logic        irq_pending_o,
    input wire logic        entry_busy_o,
    input wire logic        vector_valid_o,
    input wire logic [3:0]  vector_addr_o,
    input wire logic        global_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic ret_hold;
    wire  take_any;
    wire  take;
    // Return hold lasts until the next boundary; a boundary with a return keeps it
    always_ff @(posedge clk_i)
    begin
        if (rst_i || (instr_done_i && !return_i))
        begin
            ret_hold <= 1'b0;
        end
        else if (return_i)
        begin
            ret_hold <= 1'b1;
        end
    end
    // Take as the unit sees it; a return in the same cycle does not block it
    assign take_any = !entry_busy_o && irq_pending_o && global_enable_o && !ret_hold && instr_done_i;
    // Same-cycle return left out of the entry walk as ambiguous
    assign take = take_any && !return_i;
    sequence s_push;
        entry_busy_o [*4];
    endsequence
    sequence s_jump;
        vector_valid_o && !entry_busy_o;
    endsequence
    bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle after request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside an answer");
    dat_upper_a: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    entry_walk_a: assert property (take |=> s_push ##1 s_jump)
        else $error("entry sequence length wrong");
    take_clears_gie_a: assert property (take |=> !global_enable_o)
        else $error("global enable kept after take");
    return_sets_gie_a: assert property (return_i && !take_any |=> global_enable_o)
        else $error("return did not set global enable");
    return_hold_a: assert property (ret_hold |=> !$rose(entry_busy_o))
        else $error("entry started before post-return instruction");
    entry_cause_a: assert property ($rose(entry_busy_o) |-> $past(global_enable_o && irq_pending_o))
        else $error("entry without enabled pending request");
    vector_pulse_a: assert property (vector_valid_o |-> vector_addr_o inside {[4'h1:4'h9]} ##1 !vector_valid_o)
        else $error("vector pulse or address out of range");
    vector_hold_a: assert property (!vector_valid_o && !$rose(entry_busy_o) |-> $stable(vector_addr_o))
        else $error("vector address moved between entries");
endmodule // mif_unit_monitor

bind mif_unit mif_unit_monitor i_mif_unit_monitor (.*);

/* dv/mif_core_model.sv */
`timescale 1ns/1ps
module mif_core_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic entry_busy_i,
    input  wire logic ret_req_i,
    input  wire logic slow_i,
    output logic      instr_done_o,
    output logic      return_o
);
    logic [1:0] cnt;
    // Boundaries every 2 or 4 cycles; none while the return address is pushed
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= 2'h0;
            instr_done_o <= 1'b0;
            return_o <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 2'h1;
            return_o <= ret_req_i && !return_o;
            instr_done_o <= (slow_i ? cnt == 2'h0 : !cnt[0]) && !entry_busy_i && !ret_req_i;
        end
    end
endmodule // mif_core_model

/* dv/test_mif_unit.sv */
`timescale 1ns/1ps
module test_mif_unit;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        wen = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [9:0]  adr = 10'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [1:0]  pins = 2'b01;
    logic [7:0]  tevt = 8'h00;
    logic        done;
    logic        ret;
    logic        ret_req = 1'b0;
    logic        slow = 1'b0;
    logic        pend;
    logic        busy;
    logic        vvalid;
    logic [3:0]  vaddr;
    logic        gie;
    logic [7:0]  rd;
    logic [7:0]  regs [6];
    int          error_cnt = 0;
    int          num_checks = 0;

    mif_unit i_mif_unit (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wen),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ext_pin_i(pins), .timer_evt_i(tevt), .instr_done_i(done), .return_i(ret),
        .irq_pending_o(pend), .entry_busy_o(busy), .vector_valid_o(vvalid), .vector_addr_o(vaddr),
        .global_enable_o(gie));
    mif_core_model i_mif_core_model (.clk_i(clk_i), .rst_i(rst_i), .entry_busy_i(busy), .ret_req_i(ret_req),
        .slow_i(slow), .instr_done_o(done), .return_o(ret));

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d, input logic [3:0] s);
        @(posedge clk_i);
        {cyc, stb, wen, sel, adr, wdat} <= {2'b11, w, s, idx, 2'b00, 24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = rdat[7:0];
        {cyc, stb} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d, 4'h1);
    endtask
    task automatic rdck(input string nm, input logic [7:0] idx, input logic [7:0] exp);
        bus(idx, 1'b0, 8'h00, 4'h1);
        check(nm, rd, exp);
    endtask
    task automatic pulse(input logic [7:0] v);
        @(posedge clk_i);
        tevt <= v;
        @(posedge clk_i);
        tevt <= 8'h00;
    endtask
    // Waits for the jump, bounded so a missing vector shows as a mismatch
    task automatic wait_vec(input logic [3:0] exp);
        int n;
        n = 0;
        @(posedge clk_i);
        while (vvalid !== 1'b1 && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        check("vector", {4'h0, vaddr}, {4'h0, exp});
        check("gie_entry", {7'h0, gie}, 8'h00);
    endtask
    task automatic ret_pulse();
        @(posedge clk_i);
        ret_req <= 1'b1;
        @(posedge clk_i);
        ret_req <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("gie_return", {7'h0, gie}, 8'h01);
    endtask
    task automatic final_report();
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        final_report();
    end

    initial
    begin
        regs = '{mif_pkg::IDX_CPU_CTRL, mif_pkg::IDX_TMR_FLAGS, mif_pkg::IDX_TMR_MASK,
                 mif_pkg::IDX_EXT_FLAGS, mif_pkg::IDX_EXT_MASK, mif_pkg::IDX_GLOBAL_CTRL};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) rdck("reset", regs[i], 8'h00);
        wr(mif_pkg::IDX_TMR_MASK, 8'hff);
        rdck("tmask", mif_pkg::IDX_TMR_MASK, 8'hfd);
        bus(mif_pkg::IDX_TMR_MASK, 1'b1, 8'h00, 4'h0);
        rdck("tmask_sel", mif_pkg::IDX_TMR_MASK, 8'hfd);
        wr(mif_pkg::IDX_EXT_MASK, 8'hff);
        rdck("emask", mif_pkg::IDX_EXT_MASK, 8'hc0);
        wr(mif_pkg::IDX_EXT_MASK, 8'h00);
        wr(8'h10, 8'hff);
        rdck("unmapped", 8'h10, 8'h00);
        // Flags latch with enables off, then priority service one by one
        wr(mif_pkg::IDX_TMR_MASK, 8'h00);
        pulse(8'hff);
        rdck("tflags", mif_pkg::IDX_TMR_FLAGS, 8'hfd);
        wr(mif_pkg::IDX_TMR_FLAGS, 8'h80);
        rdck("tflags_w1c", mif_pkg::IDX_TMR_FLAGS, 8'h7d);
        pulse(8'h80);
        wr(mif_pkg::IDX_TMR_MASK, 8'hfd);
        wr(mif_pkg::IDX_GLOBAL_CTRL, 8'h80);
        for (int i = 0; i < 7; i++)
        begin
            wait_vec(4'(i + 3));
            if (i % 2 == 1)
                wr(mif_pkg::IDX_GLOBAL_CTRL, 8'h80);
            else
                ret_pulse();
        end
        rdck("tflags_served", mif_pkg::IDX_TMR_FLAGS, 8'h00);
        // External pins: pin one rising, pin zero falling
        slow <= 1'b1;
        wr(mif_pkg::IDX_GLOBAL_CTRL, 8'h00);
        wr(mif_pkg::IDX_CPU_CTRL, 8'h0e);
        pins <= 2'b10;
        repeat (4) @(posedge clk_i);
        rdck("eflags", mif_pkg::IDX_EXT_FLAGS, 8'hc0);
        wr(mif_pkg::IDX_EXT_FLAGS, 8'h40);
        rdck("eflags_w1c", mif_pkg::IDX_EXT_FLAGS, 8'h80);
        wr(mif_pkg::IDX_EXT_MASK, 8'hc0);
        wr(mif_pkg::IDX_GLOBAL_CTRL, 8'h80);
        wait_vec(4'h2);
        ret_pulse();
        rdck("eflags_served", mif_pkg::IDX_EXT_FLAGS, 8'h00);
        // Pin zero to low level while it is low
        wr(mif_pkg::IDX_CPU_CTRL, 8'h0c);
        wait_vec(4'h1);
        rdck("sense", mif_pkg::IDX_CPU_CTRL, 8'h0c);
        rdck("eflags_level", mif_pkg::IDX_EXT_FLAGS, 8'h00);
        check("pend_low", {7'h0, pend}, 8'h01);
        pins <= 2'b11;
        ret_pulse();
        check("pend_high", {7'h0, pend}, 8'h00);
        final_report();
    end
endmodule // test_mif_unit
